//--- verilog/pss_pkg.sv
// Constants, offsets and types shared by the power slot sequencer design.
// Assumes a single 25 MHz clock; times are converted into clock counts here.
package pss_pkg;
  // Clock rate and sequencing geometry
  localparam int CLK_MHZ = 25;
  localparam int NBUCK_DEF = 4;
  localparam int NLIN_DEF = 10;
  localparam int NPIN_DEF = 4;
  localparam logic [3:0] SLOT_LAST = 4'hf;
  localparam logic [3:0] SLOT_FIRST = 4'h1;
  localparam logic [3:0] SLP_SLOT_LAST = 4'h3;
  localparam int CNT_W = 16;
  // Slot delay options and the fixed sleep slot delay, in ns
  localparam int T_D0_NS = 30000;
  localparam int T_D1_NS = 200000;
  localparam int T_D2_NS = 500000;
  localparam int T_D3_NS = 2000000;
  localparam int T_SLP_NS = 120000;
  // Least times, rounded up to whole cycles
  localparam int D0_CYC = (T_D0_NS * CLK_MHZ + 999) / 1000;
  localparam int D1_CYC = (T_D1_NS * CLK_MHZ + 999) / 1000;
  localparam int D2_CYC = (T_D2_NS * CLK_MHZ + 999) / 1000;
  localparam int D3_CYC = (T_D3_NS * CLK_MHZ + 999) / 1000;
  localparam int SLP_CYC = (T_SLP_NS * CLK_MHZ + 999) / 1000;
  // Register word offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ON = 8'h04;
  localparam logic [7:0] OFS_RETAIN = 8'h08;
  localparam logic [7:0] OFS_SHUTOFF = 8'h0c;
  localparam logic [7:0] OFS_LOWPWR = 8'h10;
  localparam logic [7:0] OFS_FPWM = 8'h14;
  localparam logic [7:0] OFS_PINMAP0 = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_RES = 8'h2c;
  // Control register fields and reset values
  localparam int CTRL_SLEEP_ALLOW = 0;
  localparam int CTRL_SLEEP_POL = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [31:0] ON_RST = 32'hffffffff;
  // Status register fields
  localparam int STS_SLOT_LSB = 4;
  localparam int STS_VMON = 8;
  localparam int STS_SEQ_LSB = 16;
  // Regulator modes and sequencer states
  typedef enum logic [1:0] {PSS_OFF, PSS_NORMAL, PSS_LOWPWR, PSS_PWM} pss_mode_t;
  typedef enum logic [2:0] {ST_OFF, ST_UP, ST_ON, ST_DOWN, ST_SLP_IN, ST_SLEEP, ST_SLP_OUT} pss_state_t;
endpackage

//--- verilog/pss_mode_if.sv
// Bundle between the sequencer top and the regulator mode decoder.
// Assumes both ends share one parameter set for the regulator counts.
interface pss_mode_if
  import pss_pkg::*;
#(
  parameter int NREG = 14,
  parameter int NBUCK = 4
);
  logic [NREG-1:0] en;
  logic [NREG-1:0] assigned;
  logic [NREG-1:0] pin_state;
  logic [NREG-1:0] retain;
  logic [NREG-1:0] shutoff;
  logic [NREG-1:0] lowpwr;
  logic [NREG-1:0] in_sleep;
  logic [NBUCK-1:0] buck_force_pwm;
  logic strap_gnd;
  logic [NREG-1:0][1:0] mode;
  modport ctl (output en, assigned, pin_state, retain, shutoff, lowpwr, in_sleep, buck_force_pwm, strap_gnd,
               input mode);
  modport dec (input en, assigned, pin_state, retain, shutoff, lowpwr, in_sleep, buck_force_pwm, strap_gnd,
               output mode);
endinterface

//--- verilog/pss_mode_dec.sv
// Regulator mode decoder: pure combinational table per regulator.
// Assumes bucks occupy the low indices and linear regulators the rest.
module pss_mode_dec
  import pss_pkg::*;
#(
  parameter int NREG = 14,
  parameter int NBUCK = 4
)
(
  pss_mode_if.dec m
);
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++)
    begin : g_reg
      pss_mode_t md;
      logic slp_drop;
      // Sleep with retain clear only matters for unassigned rails off the ground strap
      assign slp_drop = !m.strap_gnd && m.in_sleep[gi] && !m.retain[gi];
      if (gi < NBUCK)
      begin : g_buck
        always_comb
        begin
          md = PSS_OFF;
          if (!m.en[gi])
            md = PSS_OFF;
          else if (m.assigned[gi])
          begin
            if (m.pin_state[gi])
              md = m.buck_force_pwm[gi] ? PSS_PWM : PSS_NORMAL;
            else if (!m.retain[gi] && m.shutoff[gi])
              md = PSS_OFF;
            else if (m.buck_force_pwm[gi])
              md = PSS_PWM;
            else
              md = m.retain[gi] ? PSS_NORMAL : PSS_LOWPWR;
          end
          else if (slp_drop)
            md = m.shutoff[gi] ? PSS_OFF : (m.buck_force_pwm[gi] ? PSS_PWM : PSS_LOWPWR);
          else
            md = m.buck_force_pwm[gi] ? PSS_PWM : (m.lowpwr[gi] ? PSS_LOWPWR : PSS_NORMAL);
        end
      end
      else
      begin : g_lin
        always_comb
        begin
          md = PSS_OFF;
          if (!m.en[gi])
            md = PSS_OFF;
          else if (m.assigned[gi])
            md = (m.pin_state[gi] || m.retain[gi]) ? PSS_NORMAL : (m.shutoff[gi] ? PSS_OFF : PSS_LOWPWR);
          else if (slp_drop)
            md = m.shutoff[gi] ? PSS_OFF : PSS_LOWPWR;
          else
            md = m.lowpwr[gi] ? PSS_LOWPWR : PSS_NORMAL;
        end
      end
      // Each regulator decodes on its own bits plus the shared ground strap
      assign m.mode[gi] = md;
    end
  endgenerate
endmodule

//--- verilog/pss_seq_top.sv
// Slot sequencer with APB register file and regulator mode outputs.
// Assumes synchronous pins, factory settings held steady on otp_* inputs,
// and a main state machine that raises power_on_req / power_off_req.
// Functional notes
// - Fifteen ordered slots at power up and down
// - Power down walks slots in reverse
// - Two-bit select picks one common slot delay
// - Slot map and delay come from factory inputs
// - All resources of a slot switch together
// - Unsequenced resources follow pins/bits when up
// - Break point holds power up until monitor good
// - Sleep entry/exit uses three 120 us slots
// - Cleared on bit forces regulator off
// - Any pin map bit makes regulator assigned
// - Pin state is OR of assigned pins
// - Assigned linear regulator mode table
// - Unassigned linear regulator mode table
// - Assigned buck converter mode table
// - Separate mode bits per regulator, independent decode
// - Sleep pin gated by allow, interrupts, polarity
module pss_seq_top
  import pss_pkg::*;
#(
  parameter int NBUCK = NBUCK_DEF,
  parameter int NLIN = NLIN_DEF,
  parameter int NPIN = NPIN_DEF,
  parameter int D1_CYCLES = D1_CYC,
  parameter int D2_CYCLES = D2_CYC,
  parameter int D3_CYCLES = D3_CYC
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [(NBUCK+NLIN+2)*4-1:0] otp_slot_map,
  input wire logic [(NBUCK+NLIN+2)*2-1:0] otp_sleep_slot,
  input wire logic [1:0] slot_delay_select,
  input wire logic [3:0] otp_break_slot,
  input wire logic power_on_req,
  input wire logic power_off_req,
  input wire logic vmon_ok,
  input wire logic sleep_pin,
  input wire logic irq_pending,
  input wire logic [NPIN-1:0] en_pins,
  input wire logic strap_select_pin,
  output logic [NBUCK*2-1:0] buck_mode,
  output logic [NLIN*2-1:0] lin_mode,
  output logic clk32_out_en,
  output logic power_good_reset_out
);
  localparam int NREG = NBUCK + NLIN;
  localparam int NRES = NREG + 2;

  pss_state_t state_r, state_nxt;
  logic [3:0] slot_r, slot_nxt, tgt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, slot_len;
  logic [NRES-1:0] seq_on_r, seq_on_nxt, slp_on_r, slp_on_nxt, hit, shit, in_seq, res_en;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [NRES-1:0] on_r, on_nxt;
  logic [NREG-1:0] ret_r, ret_nxt, shut_r, shut_nxt, lp_r, lp_nxt;
  logic [NBUCK-1:0] fpwm_r, fpwm_nxt;
  logic [NPIN-1:0][NRES-1:0] map_r, map_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [NREG-1:0][1:0] mode_r, mode_nxt;
  logic clk32_r, clk32_nxt, rstout_r, rstout_nxt;
  logic sleep_req, dev_up;
  logic [NRES-1:0] assigned, pin_state;

  // Sleep pin counts only while allowed and no interrupt waits
  assign sleep_req = ctrl_r[CTRL_SLEEP_ALLOW] && !irq_pending && (sleep_pin ^ ctrl_r[CTRL_SLEEP_POL]);
  assign dev_up = (state_r != ST_OFF) && (state_r != ST_UP) && (state_r != ST_DOWN);

  // Common slot length; the sleep path ignores the select
  always_comb
  begin
    slot_len = CNT_W'(D0_CYC - 1);
    if (state_r == ST_SLP_IN || state_r == ST_SLP_OUT || state_r == ST_ON || state_r == ST_SLEEP)
      slot_len = CNT_W'(SLP_CYC - 1);
    else
      unique case (slot_delay_select)
        2'h0: slot_len = CNT_W'(D0_CYC - 1);
        2'h1: slot_len = CNT_W'(D1_CYCLES - 1);
        2'h2: slot_len = CNT_W'(D2_CYCLES - 1);
        2'h3: slot_len = CNT_W'(D3_CYCLES - 1);
      endcase
  end

  // Next slot to process: forward on power up and sleep entry, backward on power down and sleep exit
  always_comb
  begin
    tgt = slot_r + 4'h1;
    if (state_r == ST_DOWN)
      tgt = (slot_r == 4'h0) ? SLOT_LAST : slot_r - 4'h1;
    else if (state_r == ST_SLP_OUT)
      tgt = (slot_r == 4'h0) ? SLP_SLOT_LAST : slot_r - 4'h1;
  end

  // Per-resource slot match, pin assignment and pin state
  genvar gr;
  generate
    for (gr = 0; gr < NRES; gr++)
    begin : g_res
      logic [NPIN-1:0] col;
      for (genvar gp = 0; gp < NPIN; gp++)
      begin : g_pin
        assign col[gp] = map_r[gp][gr];
      end
      assign in_seq[gr] = otp_slot_map[gr*4 +: 4] != 4'h0;
      assign hit[gr] = otp_slot_map[gr*4 +: 4] == tgt;
      assign shit[gr] = (otp_sleep_slot[gr*2 +: 2] != 2'h0) && ({2'h0, otp_sleep_slot[gr*2 +: 2]} == tgt);
      assign assigned[gr] = |col;
      assign pin_state[gr] = |(col & en_pins);
      // Sequenced resources follow the sequencer; others only while up
      assign res_en[gr] = on_r[gr] && (in_seq[gr] ? seq_on_r[gr] : dev_up);
    end
  endgenerate

  // Sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    slot_nxt = slot_r;
    seq_on_nxt = seq_on_r;
    slp_on_nxt = slp_on_r;
    cnt_nxt = (cnt_r != '0) ? cnt_r - CNT_W'(1) : cnt_r;
    unique case (state_r)
      ST_OFF:
        if (power_on_req)
        begin
          state_nxt = ST_UP;
          slot_nxt = 4'h0;
        end
      ST_UP:
        if (cnt_r == '0)
        begin
          if (slot_r == SLOT_LAST)
            state_nxt = ST_ON;
          else if (!(tgt == otp_break_slot && !vmon_ok))
          begin
            slot_nxt = tgt;
            cnt_nxt = slot_len;
            seq_on_nxt = seq_on_r | hit;
          end
        end
      ST_ON:
        if (power_off_req)
        begin
          state_nxt = ST_DOWN;
          slot_nxt = 4'h0;
        end
        else if (sleep_req)
        begin
          state_nxt = ST_SLP_IN;
          slot_nxt = 4'h0;
        end
      ST_DOWN:
        if (cnt_r == '0)
        begin
          if (slot_r == SLOT_FIRST)
          begin
            state_nxt = ST_OFF;
            slp_on_nxt = '0;
          end
          else
          begin
            slot_nxt = tgt;
            cnt_nxt = slot_len;
            seq_on_nxt = seq_on_r & ~hit;
          end
        end
      ST_SLP_IN:
        if (cnt_r == '0)
        begin
          if (slot_r == SLP_SLOT_LAST)
            state_nxt = ST_SLEEP;
          else
          begin
            slot_nxt = tgt;
            cnt_nxt = slot_len;
            slp_on_nxt = slp_on_r | shit;
          end
        end
      ST_SLEEP:
        if (power_off_req)
        begin
          state_nxt = ST_DOWN;
          slot_nxt = 4'h0;
        end
        else if (!sleep_req)
        begin
          state_nxt = ST_SLP_OUT;
          slot_nxt = 4'h0;
        end
      ST_SLP_OUT:
        if (cnt_r == '0)
        begin
          if (slot_r == SLOT_FIRST)
            state_nxt = ST_ON;
          else
          begin
            slot_nxt = tgt;
            cnt_nxt = slot_len;
            slp_on_nxt = slp_on_r & ~shit;
          end
        end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= ST_OFF;
      slot_r <= 4'h0;
      cnt_r <= '0;
      seq_on_r <= '0;
      slp_on_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      slot_r <= slot_nxt;
      cnt_r <= cnt_nxt;
      seq_on_r <= seq_on_nxt;
      slp_on_r <= slp_on_nxt;
    end
  end

  // APB slave: one wait state, answer registered, unmapped gives pslverr
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    on_nxt = on_r;
    ret_nxt = ret_r;
    shut_nxt = shut_r;
    lp_nxt = lp_r;
    fpwm_nxt = fpwm_r;
    map_nxt = map_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    pready_nxt = psel && penable && !pready_r;
    if (psel && penable && !pready_r)
    begin
      pslverr_nxt = 1'b0;
      prdata_nxt = 32'h0;
      if (paddr == OFS_CTRL)
        prdata_nxt[1:0] = ctrl_r;
      else if (paddr == OFS_ON)
        prdata_nxt[NRES-1:0] = on_r;
      else if (paddr == OFS_RETAIN)
        prdata_nxt[NREG-1:0] = ret_r;
      else if (paddr == OFS_SHUTOFF)
        prdata_nxt[NREG-1:0] = shut_r;
      else if (paddr == OFS_LOWPWR)
        prdata_nxt[NREG-1:0] = lp_r;
      else if (paddr == OFS_FPWM)
        prdata_nxt[NBUCK-1:0] = fpwm_r;
      else if (paddr >= OFS_PINMAP0 && paddr < OFS_PINMAP0 + 8'(NPIN * 4) && paddr[1:0] == 2'h0)
        prdata_nxt[NRES-1:0] = map_r[2'(paddr - OFS_PINMAP0 >> 2)];
      else if (paddr == OFS_STATUS)
        prdata_nxt = {(32-STS_SEQ_LSB)'(seq_on_r), 7'h0, vmon_ok, slot_r, 1'b0, state_r};
      else if (paddr == OFS_RES)
        prdata_nxt[NRES-1:0] = res_en;
      else
        pslverr_nxt = 1'b1;
    end
    // Writes land only at the edge that completes the transfer
    if (psel && penable && pready_r && pwrite)
    begin
      if (paddr == OFS_CTRL)
        ctrl_nxt = pwdata[1:0];
      else if (paddr == OFS_ON)
        on_nxt = pwdata[NRES-1:0];
      else if (paddr == OFS_RETAIN)
        ret_nxt = pwdata[NREG-1:0];
      else if (paddr == OFS_SHUTOFF)
        shut_nxt = pwdata[NREG-1:0];
      else if (paddr == OFS_LOWPWR)
        lp_nxt = pwdata[NREG-1:0];
      else if (paddr == OFS_FPWM)
        fpwm_nxt = pwdata[NBUCK-1:0];
      else if (paddr >= OFS_PINMAP0 && paddr < OFS_PINMAP0 + 8'(NPIN * 4) && paddr[1:0] == 2'h0)
        map_nxt[2'(paddr - OFS_PINMAP0 >> 2)] = pwdata[NRES-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_r <= CTRL_RST;
      on_r <= NRES'(ON_RST);
      ret_r <= '0;
      shut_r <= '0;
      lp_r <= '0;
      fpwm_r <= '0;
      map_r <= '0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      on_r <= on_nxt;
      ret_r <= ret_nxt;
      shut_r <= shut_nxt;
      lp_r <= lp_nxt;
      fpwm_r <= fpwm_nxt;
      map_r <= map_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Mode decode; outputs registered so the pads see no decode glitches
  pss_mode_if #(.NREG(NREG), .NBUCK(NBUCK)) mif ();
  assign mif.en = res_en[NREG-1:0];
  assign mif.assigned = assigned[NREG-1:0];
  assign mif.pin_state = pin_state[NREG-1:0];
  assign mif.retain = ret_r;
  assign mif.shutoff = shut_r;
  assign mif.lowpwr = lp_r;
  assign mif.in_sleep = slp_on_r[NREG-1:0];
  assign mif.buck_force_pwm = fpwm_r;
  assign mif.strap_gnd = strap_select_pin;

  pss_mode_dec #(.NREG(NREG), .NBUCK(NBUCK)) u_dec (.m(mif.dec));

  always_comb
  begin
    mode_nxt = mif.mode;
    clk32_nxt = res_en[NREG];
    rstout_nxt = res_en[NREG+1];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mode_r <= '0;
      clk32_r <= 1'b0;
      rstout_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      clk32_r <= clk32_nxt;
      rstout_r <= rstout_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign buck_mode = mode_r[NBUCK-1:0];
  assign lin_mode = mode_r[NREG-1:NBUCK];
  assign clk32_out_en = clk32_r;
  assign power_good_reset_out = rstout_r;

  // Checks: cycles spent in the current slot
  logic [CNT_W-1:0] dwell_r;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      dwell_r <= '0;
    else if (slot_r != slot_nxt)
      dwell_r <= '0;
    else if (dwell_r != '1)
      dwell_r <= dwell_r + CNT_W'(1);
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Entry into a walk resets the slot, so only steps within one walk are judged
  a_up_slot_order: assert property ($past(state_r) == ST_UP && state_r == ST_UP
    && $changed(slot_r) |-> slot_r == $past(slot_r) + 4'h1)
    else $error("power-up slot skipped");
  a_down_reverse: assert property ($past(state_r) == ST_DOWN && state_r == ST_DOWN && $changed(slot_r)
    && $past(slot_r) != 4'h0 |-> slot_r == $past(slot_r) - 4'h1)
    else $error("power-down slot not reversed");
  a_slot_dwell: assert property ($past(state_r) == ST_UP && state_r == ST_UP && $changed(slot_r)
    && $past(slot_r) != 4'h0 && $past(slot_delay_select) == 2'h0 |-> $past(dwell_r) == CNT_W'(D0_CYC - 1))
    else $error("slot dwell differs from delay");
  a_break_hold: assert property (state_r == ST_UP && cnt_r == '0 && tgt == otp_break_slot && !vmon_ok
    && otp_break_slot != 4'h0 |=> $stable(slot_r) && state_r == ST_UP)
    else $error("break point passed without monitor");
  a_sleep_slots: assert property (state_r == ST_SLP_IN |-> slot_r <= SLP_SLOT_LAST)
    else $error("sleep entry beyond third slot");
  a_sleep_gate: assert property (state_r == ST_ON && !power_off_req
    && (!ctrl_r[CTRL_SLEEP_ALLOW] || irq_pending) |=> state_r != ST_SLP_IN)
    else $error("sleep entered while gated");
  a_on_bit_off: assert property (!on_r[0] && $stable(on_r[0]) |=> buck_mode[1:0] == 2'h0)
    else $error("regulator on with on bit clear");
  a_manual_off: assert property (state_r == ST_OFF && $past(state_r) == ST_OFF
    |-> (!clk32_out_en || in_seq[NREG]) && (buck_mode[3:2] == 2'h0 || in_seq[1]))
    else $error("unsequenced output enabled in off state");
  a_slot_group: assert property ($past(state_r) == ST_UP && state_r == ST_UP && $changed(slot_r)
    |-> (seq_on_r & $past(hit)) == $past(hit))
    else $error("slot resources not switched together");
endmodule

//--- dv/pss_host_model.sv
// Host side model: drives the external enable pins and the sleep request pin.
// Assumes the bench sets the wanted levels; pins change just after a clock edge.
module pss_host_model
(
  input wire logic clk,
  input wire logic want_sleep,
  input wire logic sleep_low_active,
  input wire logic [3:0] en_want,
  output logic sleep_pin,
  output logic [3:0] en_pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet pins from time zero so the block never sees unknown requests
  initial
  begin
    sleep_pin = 1'b0;
    en_pins = 4'h0;
  end

  // Launched on the clock, as a synchronous host would drive them
  always @(posedge clk)
  begin
    sleep_pin <= want_sleep ^ sleep_low_active;
    en_pins <= en_want; // Only unsequenced regulators are mapped to pins
  end
endmodule

//--- dv/testbench.sv
// Self-checking bench for the slot sequencer: APB reads and output events.
// Assumes short slot delays through parameters and a host pin model.
module testbench;
  import pss_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [29:0] v; int g;} pss_note_t;
  logic clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] sel;
  logic [3:0] brk, en_want, en_pins;
  logic power_on_req, power_off_req, vmon_ok, irq_pending;
  logic want_sleep, low_act, sleep_pin, strap;
  logic [7:0] buck_mode;
  logic [19:0] lin_mode;
  logic clk32_out_en, power_good_reset_out;
  logic [29:0] obs, last;
  pss_note_t evq[$];
  logic [32:0] rdq[$];
  pss_note_t nt;
  int err_total, check_count, cyc, lastc, d;

  assign obs = {power_good_reset_out, clk32_out_en, lin_mode, buck_mode};

  pss_seq_top #(.D1_CYCLES(20), .D2_CYCLES(30), .D3_CYCLES(40)) dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .otp_slot_map(64'h1f00000000020002), .otp_sleep_slot(32'h0000d000),
    .slot_delay_select(sel), .otp_break_slot(brk), .power_on_req(power_on_req),
    .power_off_req(power_off_req), .vmon_ok(vmon_ok), .sleep_pin(sleep_pin),
    .irq_pending(irq_pending), .en_pins(en_pins), .strap_select_pin(strap),
    .buck_mode(buck_mode), .lin_mode(lin_mode), .clk32_out_en(clk32_out_en),
    .power_good_reset_out(power_good_reset_out));

  pss_host_model host (.clk(clk), .want_sleep(want_sleep), .sleep_low_active(low_act),
    .en_want(en_want), .sleep_pin(sleep_pin), .en_pins(en_pins));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic int dly(input logic [1:0] s);
    return (s == 2'h0) ? D0_CYC : 10 + 10 * int'(s);
  endfunction

  task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Gap may run one cycle long, never short: a slot must fully elapse
  task automatic cmp_ev(input logic [29:0] got, input logic [29:0] exp, input int g, input int eg);
    check_count++;
    if (got !== exp || (eg >= 0 && (g < eg || g > eg + 1)))
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h/%h exp=%h/%h", $time, got, g, exp, eg);
    end
  endtask

  // Watcher: pairs each read answer and each output change with the oldest note
  always @(posedge clk)
  begin
    cyc++;
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp_rd({pslverr, prdata}, (rdq.size() > 0) ? rdq.pop_front() : 33'bx);
    if (obs !== last)
    begin
      if (evq.size() > 0)
      begin
        nt = evq.pop_front();
        cmp_ev(obs, nt.v, cyc - lastc, nt.g);
      end
      else
        cmp_ev(obs, last, 0, -1);
      last = obs;
      lastc = cyc;
    end
  end

  // Waits for pready however long it takes; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    rdq.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic ev(input logic rs, input logic c, input logic [19:0] l, input logic [7:0] b, input int g);
    evq.push_back('{{rs, c, l, b}, g});
  endtask

  // Bounded wait for all noted events; leftovers count as mismatches
  task automatic drain;
    int n;
    n = 0;
    while (evq.size() > 0 && n < 60000)
    begin
      @(posedge clk);
      n++;
    end
    if (evq.size() > 0)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, evq.size(), 0);
      evq.delete();
    end
  endtask

  task automatic sw(input logic [7:0] a, input logic [31:0] dat, input logic [19:0] l, input logic [7:0] b);
    ev(1'b1, 1'b1, l, b, -1);
    apb(1'b1, a, dat);
    drain;
  endtask

  task automatic sp(input logic [3:0] p, input logic [19:0] l, input logic [7:0] b);
    ev(1'b1, 1'b1, l, b, -1);
    @(posedge clk);
    en_want <= p;
    drain;
  endtask

  task automatic power_up(input int dd, input logic hold, input logic un);
    ev(1'b1, 1'b0, 20'h0, 8'h0, -1);
    @(posedge clk);
    power_on_req <= 1'b1;
    @(posedge clk);
    power_on_req <= 1'b0;
    drain;
    if (hold)
    begin
      repeat (3 * dd) @(posedge clk);
      vmon_ok <= 1'b1;
    end
    ev(1'b1, 1'b0, 20'h1, 8'h1, hold ? -1 : dd);
    ev(1'b1, 1'b1, 20'h1, 8'h1, 13 * dd);
    if (un)
      ev(1'b1, 1'b1, 20'h55555, 8'h55, dd);
    drain;
    // Off requests are refused while rising, so let the last slot finish
    repeat (dd + 2) @(posedge clk);
  endtask

  task automatic power_down(input int dd);
    ev(1'b1, 1'b0, 20'h1, 8'h1, -1);
    ev(1'b1, 1'b0, 20'h0, 8'h0, 13 * dd);
    ev(1'b0, 1'b0, 20'h0, 8'h0, dd);
    @(posedge clk);
    power_off_req <= 1'b1;
    @(posedge clk);
    power_off_req <= 1'b0;
    drain;
    repeat (dd + 5) @(posedge clk);
  endtask

  task automatic results;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A hang past the expected run length ends the run as a failure
  initial
  begin
    #2800000;
    err_total++;
    results;
  end

  initial
  begin
    void'($urandom(32'h0ebd2d51));
    {psel, penable, pwrite, paddr, pwdata, power_on_req, power_off_req} = '0;
    {irq_pending, want_sleep, low_act, strap, en_want, sel, brk} = '0;
    {cyc, lastc, err_total, check_count} = '0;
    last = '0;
    vmon_ok = 1'b1;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_CTRL, {31'h0, CTRL_RST});
    rd(OFS_STATUS, 33'h100);
    r = $urandom;
    apb(1'b1, OFS_LOWPWR, r);
    rd(OFS_LOWPWR, {19'h0, r[13:0]});
    apb(1'b1, OFS_LOWPWR, 32'h0);
    apb(1'b1, 8'h30, r);
    rd(8'h30, {1'b1, 32'h0});
    apb(1'b1, OFS_STATUS, r);
    rd(OFS_STATUS, 33'h100);
    // Every delay code once; the last one also holds at a break point
    for (int s = 0; s < 4; s++)
    begin
      d = dly(s[1:0]);
      sel <= s[1:0];
      brk <= (s == 3) ? 4'h2 : 4'h0;
      vmon_ok <= (s != 3);
      power_up(d, s == 3, s == 0);
      if (s == 0)
        sw(OFS_ON, 32'h0000c011, 20'h1, 8'h1);
      power_down(d);
    end
    sel <= 2'h1;
    brk <= 4'h0;
    power_up(20, 1'b0, 1'b0);
    sw(OFS_ON, 32'h0000ffff, 20'h55555, 8'h55);
    sw(OFS_PINMAP0, 32'h22, 20'h55559, 8'h59);
    apb(1'b1, OFS_PINMAP0 + 8'h08, 32'h20);
    sp(4'h4, 20'h55555, 8'h59);
    sw(OFS_SHUTOFF, 32'h22, 20'h55555, 8'h51);
    sp(4'h0, 20'h55551, 8'h51);
    sw(OFS_RETAIN, 32'h22, 20'h55555, 8'h55);
    sw(OFS_FPWM, 32'h2, 20'h55555, 8'h5d);
    sw(OFS_RETAIN, 32'h20, 20'h55555, 8'h51);
    sp(4'h1, 20'h55555, 8'h5d);
    sw(OFS_FPWM, 32'h0, 20'h55555, 8'h55);
    sw(OFS_ON, 32'h0000fffd, 20'h55555, 8'h51);
    apb(1'b1, OFS_SHUTOFF, 32'h62);
    // Sleep request must be ignored while not allowed or an interrupt waits
    want_sleep <= 1'b1;
    repeat (50) @(posedge clk);
    irq_pending <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h3);
    low_act <= 1'b1;
    repeat (50) @(posedge clk);
    ev(1'b1, 1'b1, 20'h55545, 8'h51, -1);
    ev(1'b1, 1'b1, 20'h55585, 8'h51, 2 * SLP_CYC);
    irq_pending <= 1'b0;
    drain;
    // A ground strap keeps the low-power bit in charge even while asleep
    ev(1'b1, 1'b1, 20'h55555, 8'h51, -1);
    strap <= 1'b1;
    drain;
    ev(1'b1, 1'b1, 20'h55585, 8'h51, -1);
    strap <= 1'b0;
    drain;
    ev(1'b1, 1'b1, 20'h55545, 8'h51, -1);
    ev(1'b1, 1'b1, 20'h55555, 8'h51, 2 * SLP_CYC);
    want_sleep <= 1'b0;
    drain;
    results;
  end
endmodule
